// ==== rtl/wtp_map.vh ====
// Register map, field positions, reset values and timing counts of the watchdog.
`ifndef WTP_MAP_VH
`define WTP_MAP_VH

// ---------------------------------------------------------------
// Register addresses
// ---------------------------------------------------------------
`define WTP_ADDR_W 14
`define WTP_OPT_ADDR 14'h0081
`define WTP_OPT_ADDR_HI 14'h0181
`define WTP_CFG_ADDR 14'h2007
`define WTP_STAT_ADDR 14'h0300
`define WTP_ISTAT_ADDR 14'h0301
`define WTP_IMASK_ADDR 14'h0302

// ---------------------------------------------------------------
// Fields and reset values
// ---------------------------------------------------------------
`define WTP_OPT_RST 8'hff
`define WTP_OPT_ASSIGN 3
`define WTP_OPT_PS_HI 2
`define WTP_OPT_PS_LO 0
`define WTP_CFG_WDOG_EN 2
`define WTP_STAT_TO 0
`define WTP_STAT_SLEEP 1
`define WTP_STAT_WRST 2
`define WTP_EV_RESET 0
`define WTP_EV_WAKE 1
`define WTP_EV_W 2
`define WTP_STAT_RST 8'h01

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define WTP_CLK_PERIOD_NS 100
`define WTP_RC_PERIOD_NS 1000
`define WTP_RC_CYCLES (`WTP_RC_PERIOD_NS / `WTP_CLK_PERIOD_NS)
`define WTP_CAPTURE_CYCLES 3

`endif

// ==== rtl/wtp_counter.v ====
// Watchdog counter with the shared prescaler in front of it.
`timescale 1ns/10ps
`include "wtp_map.vh"

module wtp_counter #(
    parameter CNT_W = 8
)(
    // Clock and reset
    input wire ref_clk,
    input wire resetn,
    // Control
    input wire osc_tick,
    input wire run,
    input wire clear_all,
    input wire clear_pre,
    input wire prescaler_assign_select,
    input wire [2:0] prescale_ratio,
    // Results
    output reg [CNT_W-1:0] watchdog_counter_q,
    output reg [6:0] prescale_count_q,
    output wire time_out
);

    // ---------------------------------------------------------------
    // Ratio decode
    // ---------------------------------------------------------------
    // The prescaler step is 2**ratio, so 1:1 up to 1:128.
    function [6:0] ratio_last;
        input [2:0] r;
        begin
            ratio_last = 7'h7f >> (3'd7 - r);
        end
    endfunction

    wire pre_wrap;
    wire step;

    assign pre_wrap = (prescale_count_q == ratio_last(prescale_ratio));
    assign step = run && osc_tick && (!prescaler_assign_select || pre_wrap);
    assign time_out = step && (&watchdog_counter_q);

    // ---------------------------------------------------------------
    // Counters
    // ---------------------------------------------------------------
    always @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            watchdog_counter_q <= {CNT_W{1'b0}};
            prescale_count_q <= 7'h00;
        end
        else if (clear_all)
        begin
            watchdog_counter_q <= {CNT_W{1'b0}};
            prescale_count_q <= 7'h00;
        end
        else
        begin
            if (clear_pre || (step && prescaler_assign_select))
                prescale_count_q <= 7'h00;
            else if (run && osc_tick && prescaler_assign_select)
                prescale_count_q <= prescale_count_q + 7'h01;
            if (step)
                watchdog_counter_q <= watchdog_counter_q + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

endmodule // wtp_counter

// ==== rtl/wtp_watchdog.v ====
// Watchdog timer with prescaler: top level, register file and sleep control.
`timescale 1ns/10ps
`include "wtp_map.vh"

module wtp_watchdog #(
    parameter CNT_W = 8,
    parameter RC_CYCLES = `WTP_RC_CYCLES
)(
    // Clock and reset
    input wire ref_clk,
    input wire resetn,
    // Configuration fuses, static after power-up
    input wire [7:0] cfg_word,
    // Core instruction strobes and wake sources
    input wire clear_watchdog_instr,
    input wire sleep_instr,
    input wire irq_wake,
    // Register port
    input wire [13:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    // Core control
    output reg core_sleep,
    output reg wdt_reset,
    output reg wdt_wake,
    output wire [7:0] option_out,
    // Interrupt
    output wire irq
);

    // ---------------------------------------------------------------
    // Declarations
    // ---------------------------------------------------------------
    localparam ST_CAPTURE = 2'd0;
    localparam ST_RUN = 2'd1;
    localparam ST_SLEEP = 2'd2;

    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [7:0] cfg_meta_q;
    reg [7:0] cfg_sync_q;
    reg [7:0] cfg_word_q;
    reg [1:0] capture_cnt_q;
    reg [7:0] option_q;
    reg [7:0] option_d;
    reg time_out_flag_q;
    reg time_out_flag_d;
    reg wdt_rst_seen_q;
    reg wdt_rst_seen_d;
    reg [`WTP_EV_W-1:0] ev_status_q;
    reg [`WTP_EV_W-1:0] ev_status_d;
    reg [`WTP_EV_W-1:0] ev_mask_q;
    reg [15:0] osc_div_q;
    reg osc_tick_q;
    reg [7:0] rdata_d;

    wire watchdog_enable_fuse;
    wire prescaler_assign_select;
    wire [2:0] prescale_ratio;
    wire counting;
    wire clear_all;
    wire time_out;
    wire [CNT_W-1:0] watchdog_counter;
    wire [6:0] prescale_count;
    wire wr_opt;
    wire wr_istat;
    wire wr_imask;
    wire [`WTP_EV_W-1:0] ev_set;
    wire [7:0] status_rd;

    // ---------------------------------------------------------------
    // Address decode
    // ---------------------------------------------------------------
    // The option register answers at both of its banked addresses.
    function is_opt;
        input [13:0] a;
        begin
            is_opt = (a == `WTP_OPT_ADDR) || (a == `WTP_OPT_ADDR_HI);
        end
    endfunction

    assign wr_opt = reg_wr && is_opt(reg_addr);
    assign wr_istat = reg_wr && (reg_addr == `WTP_ISTAT_ADDR);
    assign wr_imask = reg_wr && (reg_addr == `WTP_IMASK_ADDR);

    // ---------------------------------------------------------------
    // Fuse capture
    // ---------------------------------------------------------------
    // The fuse byte is a pin level, so it passes two flops first and is
    // held from then on; later pin changes have no effect until reset.
    always @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cfg_meta_q <= 8'h00;
            cfg_sync_q <= 8'h00;
        end
        else
        begin
            cfg_meta_q <= cfg_word;
            cfg_sync_q <= cfg_meta_q;
        end
    end

    always @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cfg_word_q <= 8'h00;
            capture_cnt_q <= 2'd0;
        end
        else if (state_q == ST_CAPTURE)
        begin
            capture_cnt_q <= capture_cnt_q + 2'd1;
            if (capture_cnt_q == 2'd2)
                cfg_word_q <= cfg_sync_q;
        end
    end

    assign watchdog_enable_fuse = cfg_word_q[`WTP_CFG_WDOG_EN];

    // ---------------------------------------------------------------
    // Watchdog oscillator
    // ---------------------------------------------------------------
    // A divider of its own that no core clock gate or sleep state reaches,
    // so the count keeps going while the core is stopped.
    always @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            osc_div_q <= 16'h0000;
            osc_tick_q <= 1'b0;
        end
        else if (osc_div_q == RC_CYCLES[15:0] - 16'h0001)
        begin
            osc_div_q <= 16'h0000;
            osc_tick_q <= 1'b1;
        end
        else
        begin
            osc_div_q <= osc_div_q + 16'h0001;
            osc_tick_q <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Counter and prescaler
    // ---------------------------------------------------------------
    assign prescaler_assign_select = option_q[`WTP_OPT_ASSIGN];
    assign prescale_ratio = option_q[`WTP_OPT_PS_HI:`WTP_OPT_PS_LO];
    assign counting = watchdog_enable_fuse && (state_q != ST_CAPTURE);
    assign clear_all = (clear_watchdog_instr || sleep_instr) && (state_q == ST_RUN);

    wtp_counter #(
        .CNT_W(CNT_W)
    ) u_counter (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .osc_tick(osc_tick_q),
        .run(counting),
        .clear_all(clear_all || wdt_reset),
        .clear_pre(wr_opt && !reg_wdata[`WTP_OPT_ASSIGN]),
        .prescaler_assign_select(prescaler_assign_select),
        .prescale_ratio(prescale_ratio),
        .watchdog_counter_q(watchdog_counter),
        .prescale_count_q(prescale_count),
        .time_out(time_out)
    );

    // ---------------------------------------------------------------
    // Core state
    // ---------------------------------------------------------------
    always @*
    begin
        state_d = state_q;
        case (state_q)
            ST_CAPTURE:
            begin
                if (capture_cnt_q == 2'd2)
                    state_d = ST_RUN;
            end
            ST_RUN:
            begin
                if (sleep_instr && !time_out)
                    state_d = ST_SLEEP;
            end
            ST_SLEEP:
            begin
                if (time_out || irq_wake)
                    state_d = ST_RUN;
            end
            default:
            begin
                state_d = ST_CAPTURE;
            end
        endcase
    end

    always @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_q <= ST_CAPTURE;
            core_sleep <= 1'b0;
            wdt_reset <= 1'b0;
            wdt_wake <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            core_sleep <= (state_d == ST_SLEEP);
            wdt_reset <= time_out && (state_q == ST_RUN);
            wdt_wake <= time_out && (state_q == ST_SLEEP);
        end
    end

    // ---------------------------------------------------------------
    // Option register and status flags
    // ---------------------------------------------------------------
    // The prescaler assignment is changed by a register write or reloaded by a watchdog reset;
    // a clear-watchdog leaves it alone.
    always @*
    begin
        option_d = option_q;
        if (wr_opt)
            option_d = reg_wdata;
        if (time_out && (state_q == ST_RUN))
            option_d = `WTP_OPT_RST;
    end

    always @*
    begin
        time_out_flag_d = time_out_flag_q;
        wdt_rst_seen_d = wdt_rst_seen_q;
        if (clear_all)
        begin
            time_out_flag_d = 1'b1;
            wdt_rst_seen_d = 1'b0;
        end
        if (time_out)
            time_out_flag_d = 1'b0;
        if (time_out && (state_q == ST_RUN))
            wdt_rst_seen_d = 1'b1;
    end

    always @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            option_q <= `WTP_OPT_RST;
            time_out_flag_q <= 1'b1;
            wdt_rst_seen_q <= 1'b0;
        end
        else
        begin
            option_q <= option_d;
            time_out_flag_q <= time_out_flag_d;
            wdt_rst_seen_q <= wdt_rst_seen_d;
        end
    end

    assign option_out = option_q;

    // ---------------------------------------------------------------
    // Interrupt status and mask
    // ---------------------------------------------------------------
    // A write of one clears a bit, but an event in the same cycle wins.
    assign ev_set = {time_out && (state_q == ST_SLEEP), time_out && (state_q == ST_RUN)};

    always @*
    begin
        ev_status_d = ev_status_q;
        if (wr_istat)
            ev_status_d = ev_status_q & ~reg_wdata[`WTP_EV_W-1:0];
        ev_status_d = ev_status_d | ev_set;
    end

    always @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ev_status_q <= {`WTP_EV_W{1'b0}};
            ev_mask_q <= {`WTP_EV_W{1'b0}};
        end
        else
        begin
            ev_status_q <= ev_status_d;
            if (wr_imask)
                ev_mask_q <= reg_wdata[`WTP_EV_W-1:0];
        end
    end

    assign irq = |(ev_status_q & ev_mask_q);

    // ---------------------------------------------------------------
    // Read port
    // ---------------------------------------------------------------
    assign status_rd = {5'h00, wdt_rst_seen_q, core_sleep, time_out_flag_q};

    always @*
    begin
        rdata_d = 8'h00;
        if (is_opt(reg_addr))
            rdata_d = option_q;
        else if (reg_addr == `WTP_CFG_ADDR)
            rdata_d = cfg_word_q;
        else if (reg_addr == `WTP_STAT_ADDR)
            rdata_d = status_rd;
        else if (reg_addr == `WTP_ISTAT_ADDR)
            rdata_d = {6'h00, ev_status_q};
        else if (reg_addr == `WTP_IMASK_ADDR)
            rdata_d = {6'h00, ev_mask_q};
    end

    // Read data stand only in the cycle after the strobe, zero otherwise.
    always @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            reg_rdata <= 8'h00;
        else if (reg_rd)
            reg_rdata <= rdata_d;
        else
            reg_rdata <= 8'h00;
    end

endmodule // wtp_watchdog

// ==== sim/wtp_watchdog_checker.sv ====
// Port assertions for the watchdog timer with prescaler.
`timescale 1ns/10ps
`include "wtp_map.vh"

module wtp_watchdog_checker #(
    parameter CNT_W = 8,
    parameter RC_CYCLES = 10
)(
    // Clock and reset
    input wire ref_clk,
    input wire resetn,
    // Inputs
    input wire [7:0] cfg_word,
    input wire clear_watchdog_instr,
    input wire sleep_instr,
    input wire [13:0] reg_addr,
    input wire reg_rd,
    // Outputs
    input wire [7:0] reg_rdata,
    input wire core_sleep,
    input wire wdt_reset,
    input wire wdt_wake,
    input wire [7:0] option_out,
    input wire irq
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    // -----------------------------------------------------------
    // Fuse shadow
    // -----------------------------------------------------------
    // The fuse is static, so the last capture sample is the final one.
    reg [1:0] cap_q;
    reg fuse_q;
    always @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cap_q <= 2'h0;
            fuse_q <= 1'b1;
        end
        else if (cap_q != 2'h3)
        begin
            cap_q <= cap_q + 2'h1;
            fuse_q <= cfg_word[`WTP_CFG_WDOG_EN];
        end
    end

    // -----------------------------------------------------------
    // Properties
    // -----------------------------------------------------------
    property p_rst_run;
        wdt_reset |-> !$past(core_sleep) ##1 !wdt_reset;
    endproperty
    a_rst_run: assert property (p_rst_run)
        else $error("watchdog reset not a single pulse from run state");
    property p_wake;
        wdt_wake |-> ($past(core_sleep) && !core_sleep) ##1 !wdt_wake;
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake pulse without sleep or core still asleep");
    property p_opt_reload;
        wdt_reset |-> ##[0:1] option_out == 8'hff;
    endproperty
    a_opt_reload: assert property (p_opt_reload)
        else $error("option not reloaded after watchdog reset");
    property p_fuse_off;
        (cap_q == 2'h3 && !fuse_q) |-> !wdt_reset && !wdt_wake;
    endproperty
    a_fuse_off: assert property (p_fuse_off)
        else $error("time-out while fuse disables the watchdog");
    property p_clr_holds;
        (clear_watchdog_instr && !core_sleep) |-> ##2 !wdt_reset [*8];
    endproperty
    a_clr_holds: assert property (p_clr_holds)
        else $error("time-out right after clear instruction");
    property p_sleep_enter;
        (sleep_instr && !core_sleep) |=> core_sleep ##1 (core_sleep && !wdt_wake) [*6];
    endproperty
    a_sleep_enter: assert property (p_sleep_enter)
        else $error("sleep not entered or woken too early");
    property p_rd_idle;
        !$past(reg_rd) |-> reg_rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data not zero outside read answer");
    property p_opt_read;
        (reg_rd && reg_addr == `WTP_OPT_ADDR) |=> reg_rdata == $past(option_out);
    endproperty
    a_opt_read: assert property (p_opt_read)
        else $error("option read differs from option value");

    c_reset: cover property (wdt_reset);
    c_wake: cover property (wdt_wake);
    c_irq: cover property (irq && core_sleep == 1'b0);
endmodule // wtp_watchdog_checker

bind wtp_watchdog wtp_watchdog_checker #(.CNT_W(CNT_W), .RC_CYCLES(RC_CYCLES)) chk_u (
    .ref_clk(ref_clk), .resetn(resetn), .cfg_word(cfg_word),
    .clear_watchdog_instr(clear_watchdog_instr), .sleep_instr(sleep_instr),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .core_sleep(core_sleep), .wdt_reset(wdt_reset), .wdt_wake(wdt_wake),
    .option_out(option_out), .irq(irq));

// ==== sim/wtp_watchdog_bench.sv ====
// Self-checking testbench of the watchdog timer with prescaler.
`timescale 1ns/10ps
`include "wtp_map.vh"

module wtp_watchdog_bench;
    // Short counter and oscillator keep each time-out to at most a few hundred cycles.
    localparam int CW = 4;
    localparam int RC = 2;
    localparam int BASE = (1 << CW) * RC;
    reg ref_clk = 1'b0;
    reg resetn = 1'b0;
    reg [7:0] cfg_word = 8'hff;
    reg clear_watchdog_instr = 1'b0;
    reg sleep_instr = 1'b0;
    reg irq_wake = 1'b0;
    reg [13:0] reg_addr = 14'h0000;
    reg [7:0] reg_wdata = 8'h00;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    wire [7:0] reg_rdata;
    wire core_sleep;
    wire wdt_reset;
    wire wdt_wake;
    wire [7:0] option_out;
    wire irq;
    int err_count = 0;
    int num_checks = 0;
    int n_ev = 0;
    int s;
    logic [7:0] opt_tab [4] = '{8'h07, 8'h08, 8'h09, 8'h0b};
    int mul_tab [4] = '{1, 1, 2, 8};

    wtp_watchdog #(.CNT_W(CW), .RC_CYCLES(RC)) dut_u (
        .ref_clk(ref_clk), .resetn(resetn), .cfg_word(cfg_word),
        .clear_watchdog_instr(clear_watchdog_instr), .sleep_instr(sleep_instr),
        .irq_wake(irq_wake), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_sleep(core_sleep),
        .wdt_reset(wdt_reset), .wdt_wake(wdt_wake), .option_out(option_out), .irq(irq));

    initial
    begin
        forever #50 ref_clk = ~ref_clk;
    end

    // Counts every time-out of either kind.
    always @(posedge ref_clk)
    begin
        if (wdt_reset === 1'b1 || wdt_wake === 1'b1)
            n_ev++;
    end

    // -----------------------------------------------------------
    // Tasks
    // -----------------------------------------------------------
    task automatic stop_test;
        if (err_count == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_win(input int n, input int lo, input int hi);
        num_checks++;
        if (n < lo || n > hi)
        begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h to %h", $time, n, lo, hi);
        end
    endtask

    task automatic wr(input logic [13:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [13:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask

    task automatic instr(input bit slp);
        @(posedge ref_clk);
        sleep_instr <= slp;
        clear_watchdog_instr <= !slp;
        @(posedge ref_clk);
        sleep_instr <= 1'b0;
        clear_watchdog_instr <= 1'b0;
    endtask

    // Waits for a time-out pulse; the bound is a hang and ends the run.
    task automatic wait_ev(input bit wake, input int lo, input int hi);
        int n;
        n = 0;
        while ((wake ? wdt_wake : wdt_reset) !== 1'b1)
        begin
            @(posedge ref_clk);
            #1;
            n++;
            if (n > hi)
            begin
                err_count++;
                stop_test;
            end
        end
        chk_win(n, lo, hi);
    endtask

    task automatic do_reset(input logic [7:0] cfg);
        resetn <= 1'b0;
        cfg_word <= cfg;
        repeat (2) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (4) @(posedge ref_clk);
    endtask

    // -----------------------------------------------------------
    // Sequence
    // -----------------------------------------------------------
    initial
    begin
        do_reset(8'hff);
        rd(`WTP_OPT_ADDR, `WTP_OPT_RST);
        rd(`WTP_OPT_ADDR_HI, `WTP_OPT_RST);
        rd(`WTP_STAT_ADDR, `WTP_STAT_RST);
        rd(`WTP_CFG_ADDR, 8'hff);
        rd(14'h0123, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            wr(`WTP_OPT_ADDR, opt_tab[i]);
            instr(1'b0);
            wait_ev(1'b0, BASE * mul_tab[i] - RC - 2, BASE * mul_tab[i] + RC + 8);
            rd(`WTP_OPT_ADDR, `WTP_OPT_RST);
            rd(`WTP_STAT_ADDR, 8'h04);
        end
        rd(`WTP_ISTAT_ADDR, 8'h01);
        wr(`WTP_IMASK_ADDR, 8'h01);
        #1;
        chk({7'h00, irq}, 8'h01);
        wr(`WTP_ISTAT_ADDR, 8'h01);
        rd(`WTP_ISTAT_ADDR, 8'h00);
        chk({7'h00, irq}, 8'h00);
        // A second clear halfway restarts the prescaled period.
        wr(`WTP_OPT_ADDR_HI, 8'h0b);
        instr(1'b0);
        repeat (4 * BASE) @(posedge ref_clk);
        instr(1'b0);
        rd(`WTP_OPT_ADDR, 8'h0b);
        wait_ev(1'b0, 8 * BASE - RC - 6, 8 * BASE + RC + 8);
        wr(`WTP_OPT_ADDR, 8'h07);
        s = n_ev;
        repeat (5)
        begin
            repeat (BASE - 10) @(posedge ref_clk);
            instr(1'b0);
        end
        chk(8'(n_ev - s), 8'h00);
        wait_ev(1'b0, BASE - RC - 2, BASE + RC + 8);
        wr(`WTP_ISTAT_ADDR, 8'h01);
        wr(`WTP_OPT_ADDR, 8'h07);
        wr(`WTP_IMASK_ADDR, 8'h02);
        s = n_ev;
        instr(1'b1);
        #1;
        chk({7'h00, core_sleep}, 8'h01);
        wait_ev(1'b1, BASE - RC - 2, BASE + RC + 8);
        chk({7'h00, core_sleep}, 8'h00);
        wr(`WTP_OPT_ADDR, 8'h0f);
        chk(8'(n_ev - s), 8'h01);
        rd(`WTP_STAT_ADDR, 8'h00);
        chk({7'h00, irq}, 8'h01);
        wr(`WTP_IMASK_ADDR, 8'h01);
        #1;
        chk({7'h00, irq}, 8'h00);
        wr(`WTP_ISTAT_ADDR, 8'h02);
        wr(`WTP_IMASK_ADDR, 8'h02);
        #1;
        chk({7'h00, irq}, 8'h00);
        // An interrupt wake leaves sleep without a watchdog pulse or time-out.
        instr(1'b1);
        repeat (10) @(posedge ref_clk);
        irq_wake <= 1'b1;
        @(posedge ref_clk);
        irq_wake <= 1'b0;
        #1;
        chk({7'h00, core_sleep}, 8'h00);
        rd(`WTP_STAT_ADDR, 8'h01);
        chk(8'(n_ev - s), 8'h01);
        do_reset(8'hfb);
        rd(`WTP_CFG_ADDR, 8'hfb);
        wr(`WTP_OPT_ADDR, 8'h07);
        instr(1'b0);
        s = n_ev;
        repeat (3 * BASE) @(posedge ref_clk);
        chk(8'(n_ev - s), 8'h00);
        stop_test;
    end
endmodule // wtp_watchdog_bench
